// *** inc/rcsp_pkg.sv ***
// Constants and carrier types of the reference select and pulse block.
package rcsp_pkg;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL          = 8'h00;
  localparam logic [7:0] A_EXT_REF_SETUP = 8'h04;
  localparam logic [7:0] A_PULSE_SETUP   = 8'h08;
  localparam logic [7:0] A_PULSE_SHIFT   = 8'h0C;
  localparam logic [7:0] A_STATUS        = 8'h10;
  localparam logic [7:0] A_IRQ_STATUS    = 8'h14;
  localparam logic [7:0] A_IRQ_MASK      = 8'h18;
  // Control fields.
  localparam int C_RETAIN = 0;
  localparam int C_AUTO   = 1;
  localparam int C_FALL   = 2;
  localparam int C_SER    = 4;
  // Status fields.
  localparam int S_EXT    = 0;
  localparam int S_LOCK   = 1;
  localparam int S_OPT    = 2;
  localparam int S_ALARM  = 3;
  localparam int S_FALLBK = 4;
  // Interrupt fields.
  localparam int I_LOSS  = 0;
  localparam int I_PULSE = 1;
  // Reference frequency in 10 kHz units.
  localparam logic [11:0] FREQ_MAX = 12'h834;
  localparam logic [11:0] FREQ_MIN = 12'h064;
  localparam logic [11:0] FREQ_RST = 12'h000;
  // Pulse period in half seconds.
  localparam logic [6:0] PER_MAX = 7'h78;
  localparam logic [6:0] PER_MIN = 7'h01;
  localparam logic [6:0] PER_RST = 7'h02;
  // Times.
  localparam int CLK_NS      = 40;
  localparam int SEC_NS      = 1_000_000_000;
  localparam int PULSE_US    = 1500;
  localparam int OFS_STEP_NS = 100;
  localparam int OFS_MAX_NS  = 500_000_000;
  localparam int OFS_MAX     = OFS_MAX_NS / OFS_STEP_NS;
  localparam int TMR_W       = 16;
  localparam int PHASE_W     = 25;

  typedef struct packed {
    logic lock;
    logic freq_ok;
    logic power_ok;
  } rcsp_ref_type;

  typedef struct packed {
    logic               retain;
    logic               auto_sw;
    logic               fall_edge;
    logic [3:0]         ser_en;
    logic [11:0]        freq;
    logic [6:0]         period;
    logic signed [23:0] shift;
  } rcsp_cfg_type;

  typedef struct packed {
    rcsp_cfg_type         cfg;
    logic                 fallen;
    logic                 loss_d;
    logic                 use_ext;
    logic                 osc_en;
    logic                 alarm;
    logic [1:0]           irq;
    logic [1:0]           mask;
    logic                 irq_out;
    logic [31:0]          rdata;
    logic [PHASE_W-1:0]   phase;
    logic [6:0]           halves;
    logic                 resync;
    logic                 ded_out;
    logic [3:0]           ser_out;
  } rcsp_top_type;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             lvl;
  } rcsp_tmr_type;
endpackage : rcsp_pkg

// *** hw/rcsp_sync.sv ***
// Two flip-flop synchroniser for asynchronous input pins.
`timescale 1ns/1ps
module rcsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  import rcsp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rcsp_sync_type;

  rcsp_sync_type st;
  rcsp_sync_type next_st;

  initial
  begin
    if (W < 1) $error("rcsp_sync: W must be positive.");
  end

  always_comb
  begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i) st <= '0;
    else st <= next_st;
  end

  assign q_o = st.s2;
endmodule : rcsp_sync

// *** hw/rcsp_pulse_timer.sv ***
// One-shot high pulse of a fixed number of clock cycles.
`timescale 1ns/1ps
module rcsp_pulse_timer #(
  parameter int WIDTH_CYC = 1
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      level_o
);
  import rcsp_pkg::*;

  rcsp_tmr_type st;
  rcsp_tmr_type next_st;

  initial
  begin
    if (WIDTH_CYC < 1 || WIDTH_CYC >= (1 << TMR_W))
      $error("rcsp_pulse_timer: WIDTH_CYC out of range.");
  end

  // A start during a running pulse restarts the width.
  always_comb
  begin
    next_st = st;
    if (start_i)
    begin
      next_st.cnt = TMR_W'(WIDTH_CYC - 1);
      next_st.lvl = 1'b1;
    end
    else if (st.cnt != '0)
      next_st.cnt = st.cnt - 1'b1;
    else
      next_st.lvl = 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i) st <= '0;
    else st <= next_st;
  end

  assign level_o = st.lvl;

  property p_width;
    @(posedge clock_i) disable iff (rst_i)
    start_i |=> level_o ##0 (st.cnt == TMR_W'(WIDTH_CYC - 1));
  endproperty
  a_width: assert property (p_width)
    else $error("Pulse did not start with the full width.");
endmodule : rcsp_pulse_timer

// *** hw/rcsp_top.sv ***
// Reference select and satellite-timed pulse generator.
`timescale 1ns/1ps
module rcsp_top #(
  parameter int CYC_SEC   = rcsp_pkg::SEC_NS / rcsp_pkg::CLK_NS,
  parameter int PULSE_CYC = (rcsp_pkg::PULSE_US * 1000) / rcsp_pkg::CLK_NS
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic                  option_installed_i,
  input  wire rcsp_pkg::rcsp_ref_type ref_status_i,
  input  wire logic                  sat_second_i,
  input  wire logic                  warm_restart_i,
  output logic [31:0]                rdata_o,
  output logic                       irq_o,
  output logic                       use_external_o,
  output logic                       internal_crystal_oscillator_en_o,
  output logic                       alarm_o,
  output logic                       dedicated_timing_pulse_output_o,
  output logic [3:0]                 serial_pulse_o
);
  import rcsp_pkg::*;

  localparam int HALF_CYC = CYC_SEC / 2;

  initial
  begin
    if (CYC_SEC < 4 || CYC_SEC >= (1 << PHASE_W))
      $error("rcsp_top: CYC_SEC out of range.");
    if (PULSE_CYC < 1 || PULSE_CYC >= HALF_CYC)
      $error("rcsp_top: PULSE_CYC must be shorter than half a second.");
  end

  function automatic logic freq_valid(input logic [31:0] v);
    freq_valid = (v == 32'h0) ||
                 (v >= 32'(FREQ_MIN) && v <= 32'(FREQ_MAX));
  endfunction : freq_valid

  function automatic logic period_valid(input logic [31:0] v);
    period_valid = v >= 32'(PER_MIN) && v <= 32'(PER_MAX);
  endfunction : period_valid

  function automatic logic shift_valid(input logic [31:0] v);
    int s;
    s = int'(signed'(v));
    shift_valid = (s >= -OFS_MAX) && (s <= OFS_MAX);
  endfunction : shift_valid

  rcsp_top_type st;
  rcsp_top_type next_st;
  rcsp_ref_type ref_s;
  logic         opt_s;
  logic         loss_cond;
  logic         loss_evt;
  logic         ext_sel;
  logic         fire;
  logic         ded_start;
  logic         ser_start;
  logic         ded_lvl;
  logic         ser_lvl;
  int           shift_cyc;
  int           tp_a;
  int           tp_b;
  int           tp_c;

  // Pins from the reference source and the option strap are asynchronous.
  rcsp_sync #(
    .W(4)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i  (rst_i),
    .d_i    ({option_installed_i, ref_status_i}),
    .q_o    ({opt_s, ref_s})
  );

  rcsp_pulse_timer #(
    .WIDTH_CYC(PULSE_CYC)
  ) u_ded (
    .clock_i(clock_i),
    .rst_i  (rst_i),
    .start_i(ded_start),
    .level_o(ded_lvl)
  );

  rcsp_pulse_timer #(
    .WIDTH_CYC(PULSE_CYC)
  ) u_ser (
    .clock_i(clock_i),
    .rst_i  (rst_i),
    .start_i(ser_start),
    .level_o(ser_lvl)
  );

  // Any one of the three conditions counts as loss of the reference.
  assign loss_cond = ~(ref_s.lock & ref_s.freq_ok & ref_s.power_ok);
  assign loss_evt  = st.use_ext & loss_cond & ~st.loss_d;
  assign ext_sel   = opt_s & (st.cfg.freq != FREQ_RST) & ~st.fallen;

  // Trigger phase within the second. Falling-edge alignment starts the
  // pulse one width early so that its falling edge lands on the mark.
  assign shift_cyc = (int'(st.cfg.shift) * OFS_STEP_NS) / CLK_NS;
  assign tp_c = shift_cyc - (st.cfg.fall_edge ? PULSE_CYC : 0);
  assign tp_a = (tp_c % CYC_SEC < 0) ? tp_c % CYC_SEC + CYC_SEC
                                     : tp_c % CYC_SEC;
  assign tp_b = (tp_a + HALF_CYC >= CYC_SEC) ? tp_a + HALF_CYC - CYC_SEC
                                             : tp_a + HALF_CYC;

  assign fire = (st.phase == PHASE_W'(tp_a)) ||
                (st.phase == PHASE_W'(tp_b));

  // The resync start only happens on the whole-second trigger so that even
  // periods keep their pulses on whole seconds of satellite time.
  assign ded_start = fire &&
                     ((st.halves == 7'(st.cfg.period - PER_MIN)) ||
                      (st.resync && st.phase == PHASE_W'(tp_a)));
  assign ser_start = (st.phase == '0);

  always_comb
  begin
    next_st = st;

    // Satellite second mark realigns the phase counter.
    if (sat_second_i)
      next_st.phase = '0;
    else if (st.phase == PHASE_W'(CYC_SEC - 1))
      next_st.phase = '0;
    else
      next_st.phase = st.phase + 1'b1;

    if (ded_start)
    begin
      next_st.halves = '0;
      next_st.resync = 1'b0;
    end
    else if (fire)
      next_st.halves = st.halves + 1'b1;

    next_st.ded_out = ded_lvl;
    next_st.ser_out = st.cfg.ser_en & {4{ser_lvl}};

    // Source selection and lock-loss handling.
    next_st.use_ext = ext_sel;
    next_st.osc_en  = ~ext_sel;
    next_st.loss_d  = loss_cond & st.use_ext;
    if (loss_evt && st.cfg.auto_sw)
      next_st.fallen = 1'b1;
    next_st.alarm = st.use_ext & loss_cond & ~st.cfg.auto_sw;

    // Register writes.
    if (wr_i)
    begin
      case (addr_i)
        A_CTRL:
        begin
          next_st.cfg.retain    = wdata_i[C_RETAIN];
          next_st.cfg.auto_sw   = wdata_i[C_AUTO];
          next_st.cfg.fall_edge = wdata_i[C_FALL];
          next_st.cfg.ser_en    = wdata_i[C_SER +: 4];
          next_st.resync        = 1'b1;
        end
        A_EXT_REF_SETUP:
        begin
          // Without the option the setting does not exist.
          if (opt_s && freq_valid(wdata_i))
          begin
            next_st.cfg.freq = wdata_i[11:0];
            next_st.fallen   = 1'b0;
          end
        end
        A_PULSE_SETUP:
        begin
          if (period_valid(wdata_i))
          begin
            next_st.cfg.period = wdata_i[6:0];
            next_st.resync     = 1'b1;
          end
        end
        A_PULSE_SHIFT:
        begin
          if (shift_valid(wdata_i))
          begin
            next_st.cfg.shift = wdata_i[23:0];
            next_st.resync    = 1'b1;
          end
        end
        A_IRQ_MASK:
          next_st.mask = wdata_i[1:0];
        default:
          ;
      endcase
    end

    // Power cycle without retention loses the reference setup.
    if (warm_restart_i && !st.cfg.retain)
    begin
      next_st.cfg.freq = FREQ_RST;
      next_st.fallen   = 1'b0;
    end

    // Write one to clear; a new event in the same cycle wins.
    if (wr_i && addr_i == A_IRQ_STATUS)
      next_st.irq = st.irq & ~wdata_i[1:0];
    if (loss_evt)
      next_st.irq[I_LOSS] = 1'b1;
    if (ded_start)
      next_st.irq[I_PULSE] = 1'b1;
    next_st.irq_out = |(next_st.irq & next_st.mask);

    // Read data stand for exactly one cycle after the strobe.
    next_st.rdata = '0;
    if (rd_i)
    begin
      case (addr_i)
        A_CTRL:
        begin
          next_st.rdata[C_RETAIN]   = st.cfg.retain;
          next_st.rdata[C_AUTO]     = st.cfg.auto_sw;
          next_st.rdata[C_FALL]     = st.cfg.fall_edge;
          next_st.rdata[C_SER +: 4] = st.cfg.ser_en;
        end
        A_EXT_REF_SETUP:
          next_st.rdata[11:0] = st.cfg.freq;
        A_PULSE_SETUP:
          next_st.rdata[6:0] = st.cfg.period;
        A_PULSE_SHIFT:
          next_st.rdata = 32'(st.cfg.shift);
        A_STATUS:
        begin
          next_st.rdata[S_EXT]    = st.use_ext;
          next_st.rdata[S_LOCK]   = ~loss_cond;
          next_st.rdata[S_OPT]    = opt_s;
          next_st.rdata[S_ALARM]  = st.alarm;
          next_st.rdata[S_FALLBK] = st.fallen;
        end
        A_IRQ_STATUS:
          next_st.rdata[1:0] = st.irq;
        A_IRQ_MASK:
          next_st.rdata[1:0] = st.mask;
        default:
          ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st            <= '0;
      st.cfg.freq   <= FREQ_RST;
      st.cfg.period <= PER_RST;
      st.osc_en     <= 1'b1;
      st.resync     <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign rdata_o                          = st.rdata;
  assign irq_o                            = st.irq_out;
  assign use_external_o                   = st.use_ext;
  assign internal_crystal_oscillator_en_o = st.osc_en;
  assign alarm_o                          = st.alarm;
  assign dedicated_timing_pulse_output_o  = st.ded_out;
  assign serial_pulse_o                   = st.ser_out;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_osc;
    use_external_o ^ internal_crystal_oscillator_en_o;
  endproperty
  a_osc: assert property (p_osc)
    else $error("Oscillator enable and external select disagree.");

  property p_zero;
    (st.cfg.freq == FREQ_RST) |=> !use_external_o;
  endproperty
  a_zero: assert property (p_zero)
    else $error("External reference used with zero frequency.");

  property p_opt;
    !opt_s |=> !use_external_o;
  endproperty
  a_opt: assert property (p_opt)
    else $error("External reference used without the option.");

  property p_fallback;
    loss_evt && st.cfg.auto_sw |-> ##2 !use_external_o;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("No fallback to internal oscillator after loss.");

  property p_stay;
    use_external_o && loss_cond && !st.cfg.auto_sw && ext_sel
      |=> alarm_o && use_external_o;
  endproperty
  a_stay: assert property (p_stay)
    else $error("Loss without fallback did not alarm and stay.");

  property p_sticky;
    loss_evt |=> st.irq[I_LOSS] ##1 (st.irq[I_LOSS] ||
                 $past(wr_i && addr_i == A_IRQ_STATUS && wdata_i[I_LOSS]));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("Lock-loss flag not latched.");

  property p_freq;
    wr_i && addr_i == A_EXT_REF_SETUP && !freq_valid(wdata_i)
      |=> $stable(st.cfg.freq);
  endproperty
  a_freq: assert property (p_freq)
    else $error("Invalid reference frequency was accepted.");

  property p_period;
    wr_i && addr_i == A_PULSE_SETUP && !period_valid(wdata_i)
      |=> $stable(st.cfg.period);
  endproperty
  a_period: assert property (p_period)
    else $error("Invalid pulse period was accepted.");

  property p_serial;
    (st.phase == '0) && !sat_second_i |-> ##2
      (serial_pulse_o == $past(st.cfg.ser_en));
  endproperty
  a_serial: assert property (p_serial)
    else $error("Serial pulse not issued at the second mark.");
endmodule : rcsp_top

// *** test/rcsp_partner.sv ***
// Model of the external reference source and the satellite second marker.
`timescale 1ns/1ps
module rcsp_partner #(
  parameter int CYC_SEC = 200
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [1:0]       fault_i,
  output rcsp_pkg::rcsp_ref_type ref_status_o,
  output logic                  sat_second_o
);
  import rcsp_pkg::*;
  int cnt;

  // Fault code 1 drops lock, 2 drifts out of range, 3 cuts source power.
  always_comb
  begin
    ref_status_o.lock     = fault_i != 2'h1;
    ref_status_o.freq_ok  = fault_i != 2'h2;
    ref_status_o.power_ok = fault_i != 2'h3;
  end

  // One marker pulse per satellite second, a single clock wide. The mark
  // stands in the cycle before phase zero, so that it never repeats a zero
  // phase and doubles the half-second count of the block.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt          <= 0;
      sat_second_o <= 1'b0;
    end
    else
    begin
      cnt          <= (cnt == CYC_SEC - 1) ? 0 : cnt + 1;
      sat_second_o <= cnt == CYC_SEC - 2;
    end
  end
endmodule : rcsp_partner

// *** test/rcsp_top_tb.sv ***
// Self-checking bench of the reference select and pulse block.
`timescale 1ns/1ps
module rcsp_top_tb;
  import rcsp_pkg::*;
  localparam int CS = 200;
  localparam int PC = 5;
  logic         clock_i = 1'b0;
  logic         rst_i   = 1'b1;
  logic [7:0]   addr_i  = 8'h00;
  logic [31:0]  wdata_i = 32'h0;
  logic         wr_i    = 1'b0;
  logic         rd_i    = 1'b0;
  logic         opt     = 1'b1;
  logic         warm    = 1'b0;
  logic [1:0]   fault   = 2'h0;
  rcsp_ref_type ref_st;
  logic         sat, irq, use_ext, osc_en, alarm, ded;
  logic [31:0]  rdata;
  logic [3:0]   ser;
  logic [3:0]   ser_m   = 4'h0;
  logic [31:0]  exp_q[$];
  logic         rd_d    = 1'b0;
  logic         ded_d   = 1'b0;
  logic         ser_d   = 1'b0;
  logic [11:0]  f;
  int           errors  = 0;
  int           check_count = 0;
  int           cyc = 0, ded_n = 0, ded_t = 0, ded_p = 0, ser_t = 0;
  int           per_c[6] = '{2, 1, 4, 2, 2, 2};
  int           sh_c[6]  = '{0, 0, 0, 0, 4, -4};
  int           fl_c[6]  = '{0, 0, 0, 1, 0, 0};

  always #20 clock_i = ~clock_i;

  rcsp_partner #(.CYC_SEC(CS)) rcsp_partner_inst (
    .clock_i(clock_i), .rst_i(rst_i), .fault_i(fault),
    .ref_status_o(ref_st), .sat_second_o(sat));

  rcsp_top #(.CYC_SEC(CS), .PULSE_CYC(PC)) rcsp_top_inst (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .option_installed_i(opt),
    .ref_status_i(ref_st), .sat_second_i(sat), .warm_restart_i(warm),
    .rdata_o(rdata), .irq_o(irq), .use_external_o(use_ext),
    .internal_crystal_oscillator_en_o(osc_en), .alarm_o(alarm),
    .dedicated_timing_pulse_output_o(ded), .serial_pulse_o(ser));

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  // The expected word is queued here and compared when the data appear.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask : rd

  task automatic restart;
    @(posedge clock_i);
    warm <= 1'b1;
    @(posedge clock_i);
    warm <= 1'b0;
    settle(3);
  endtask : restart

  always @(posedge clock_i)
  begin
    cyc  <= cyc + 1;
    rd_d <= rd_i;
    if (cyc > 30000)
    begin
      errors++;
      end_sim();
    end
  end

  // Sampling on the falling edge keeps the watcher clear of update races.
  always @(negedge clock_i)
  begin
    if (rd_d)
      check(rdata, exp_q.pop_front());
    if (ser != 4'h0 && !ser_d)
    begin
      if (ser_t > 0)
        check(32'(cyc - ser_t), 32'(CS));
      check(32'(ser), 32'(ser_m));
      ser_t = cyc;
    end
    if (ded && !ded_d)
    begin
      ded_p = ded_t;
      ded_t = cyc;
      ded_n++;
    end
    if (!ded && ded_d)
      check(32'(cyc - ded_t), 32'(PC));
    ded_d = ded;
    ser_d = ser != 4'h0;
  end

  initial
  begin
    int e;
    int tgt;
    void'($urandom(14450));
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    settle(1);
    check(32'(osc_en), 32'h1);
    rd(A_EXT_REF_SETUP, 32'h0);
    rd(A_PULSE_SETUP, 32'h2);
    rd(A_CTRL, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0);
    @(posedge clock_i);
    opt <= 1'b0;
    settle(4);
    wr(A_EXT_REF_SETUP, 32'h64);
    settle(4);
    check(32'(use_ext), 32'h0);
    rd(A_EXT_REF_SETUP, 32'h0);
    @(posedge clock_i);
    opt <= 1'b1;
    settle(4);
    wr(A_EXT_REF_SETUP, 32'h835);
    wr(A_EXT_REF_SETUP, 32'h63);
    rd(A_EXT_REF_SETUP, 32'h0);
    f = 12'($urandom_range(2100, 100));
    wr(A_EXT_REF_SETUP, 32'(f));
    rd(A_EXT_REF_SETUP, 32'(f));
    settle(4);
    check(32'(use_ext), 32'h1);
    check(32'(osc_en), 32'h0);
    wr(A_IRQ_MASK, 32'h1);
    for (int k = 1; k < 4; k++)
    begin
      wr(A_CTRL, 32'h2);
      wr(A_EXT_REF_SETUP, 32'(f));
      settle(4);
      @(posedge clock_i);
      fault <= 2'(k);
      settle(8);
      check(32'(use_ext), 32'h0);
      @(posedge clock_i);
      fault <= 2'h0;
      settle(8);
      check(32'(irq), 32'h1);
      rd(A_STATUS, 32'h16);
      wr(A_IRQ_STATUS, 32'h1);
      settle(2);
      check(32'(irq), 32'h0);
    end
    wr(A_CTRL, 32'h0);
    wr(A_EXT_REF_SETUP, 32'(f));
    settle(4);
    @(posedge clock_i);
    fault <= 2'h1;
    settle(8);
    check(32'(alarm), 32'h1);
    check(32'(use_ext), 32'h1);
    @(posedge clock_i);
    fault <= 2'h0;
    settle(8);
    check(32'(alarm), 32'h0);
    check(32'(irq), 32'h1);
    wr(A_IRQ_STATUS, 32'h1);
    restart();
    rd(A_EXT_REF_SETUP, 32'h0);
    check(32'(use_ext), 32'h0);
    wr(A_CTRL, 32'h1);
    wr(A_EXT_REF_SETUP, 32'(f));
    restart();
    rd(A_EXT_REF_SETUP, 32'(f));
    check(32'(use_ext), 32'h1);
    ser_m = 4'($urandom_range(15, 1));
    for (int i = 0; i < 6; i++)
    begin
      wr(A_PULSE_SETUP, 32'(per_c[i]));
      wr(A_PULSE_SHIFT, 32'(sh_c[i]));
      wr(A_CTRL, 32'(ser_m) << C_SER | 32'(fl_c[i]) << C_FALL);
      e = (sh_c[i] * OFS_STEP_NS / CLK_NS - fl_c[i] * PC + CS) % (CS / 2);
      tgt = ded_n + 3;
      repeat (1200) if (ded_n < tgt) @(posedge clock_i);
      check(32'(ded_t - ded_p), 32'(per_c[i] * CS / 2));
      check(32'((ded_t - ser_t) % (CS / 2)), 32'(e));
      if (i == 0)
        check(32'((ded_t - ser_t) % CS), 32'h0);
    end
    wr(A_PULSE_SHIFT, 32'h004C4B41);
    rd(A_PULSE_SHIFT, 32'hFFFFFFFC);
    wr(A_PULSE_SETUP, 32'h0);
    wr(A_PULSE_SETUP, 32'h79);
    rd(A_PULSE_SETUP, 32'h2);
    settle(3);
    end_sim();
  end
endmodule : rcsp_top_tb
